// *** rtl/ssc_top.sv ***
`timescale 1ns/100ps
`default_nettype none

// How it works
// - The first actuator seen in range is learned automatically.
// - Once learned, no other actuator is learned until power is cycled.
// - Health lamp is steady green while ready.
// - Actuator lamp is lit while the learned actuator is in range.
// - Input lamp is steady while both safety inputs are high, unless a plausibility error is held.
// - One input falling while the other stays high makes the input lamp blink.
// - A fault turns health red and plays a flash code on a chosen lamp.
// - A fault stays until power is cycled.
// - Each sequence opens with three short flashes.
// - After a longer pause, digit flashes come one per second.
// - Long flashes per group equal the digit value.
// - A code has one to three digits, each its own group.
// - Digit groups are split by a gap longer than the flash interval.
// - The sequence repeats endlessly while the fault remains.
// - Digits 1 to 15 flash their count; zero flashes sixteen times.
// - Wiring faults are codes 1.4.1, 1.12, 1.13, 14 and 15.
// - Every other code is an internal device error.
// - Chain switch-off delay adds one input delay per extra switch.
// - A plausibility error locks outputs until both inputs have been low.
// - In the safe state both safety outputs are low.
module ssc_top #(
    parameter int TICK_CYCLES = ssc_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic actDetect,
    input wire logic [ssc_pkg::ID_W-1:0] actId,
    input wire logic safety_in_ch1,
    input wire logic safety_in_ch2,
    input wire logic faultReport,
    input wire logic [1:0] faultDigitCount,
    input wire logic [ssc_pkg::DIGIT_W-1:0] faultDigit0,
    input wire logic [ssc_pkg::DIGIT_W-1:0] faultDigit1,
    input wire logic [ssc_pkg::DIGIT_W-1:0] faultDigit2,
    input wire logic faultLamp,
    output logic healthLedGreen,
    output logic healthLedRed,
    output logic actuator_present_led,
    output logic input_state_led,
    output logic safetyOutCh1,
    output logic safetyOutCh2,
    output logic aux_signal_out,
    output logic learnedFlag,
    output logic wiringFault,
    output logic internalFault,
    output logic partialLock
);

    localparam logic [ssc_pkg::MS_W-1:0] POWER_ON_LAST = ssc_pkg::MS_W'(ssc_pkg::POWER_ON_MS - 1);
    localparam logic [ssc_pkg::MS_W-1:0] BLINK_LAST = ssc_pkg::MS_W'(ssc_pkg::BLINK_HALF_MS - 1);

    logic msTick;
    logic flashOn;
    logic ready_r;
    logic [ssc_pkg::MS_W-1:0] powerCnt_r;
    logic [ssc_pkg::MS_W-1:0] blinkCnt_r;
    logic blink_r;
    logic learned_r;
    logic [ssc_pkg::ID_W-1:0] learnedId_r;
    logic inRange;
    logic prevCh1_r;
    logic prevCh2_r;
    logic mismatch_r;
    logic lock_r;
    logic bothHigh;
    logic bothLow;
    logic fault_r;
    logic [1:0] codeCount_r;
    logic [ssc_pkg::DIGIT_W-1:0] code0_r;
    logic [ssc_pkg::DIGIT_W-1:0] code1_r;
    logic [ssc_pkg::DIGIT_W-1:0] code2_r;
    logic lamp_r;
    logic wiring_r;
    logic [1:0] countClamp;
    logic outCh1_r;
    logic outCh2_r;
    logic aux_r;
    logic presentLed_r;
    logic inputLed_r;

    ssc_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .tick(msTick)
    );

    // Switch-on delay after power is applied.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            powerCnt_r <= '0;
            ready_r <= 1'b0;
        end
        else if (msTick && !ready_r)
        begin
            if (powerCnt_r == POWER_ON_LAST)
                ready_r <= 1'b1;
            else
                powerCnt_r <= powerCnt_r + ssc_pkg::MS_W'(1);
        end
    end

    // Blink pacing for the partial-operation display.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            blinkCnt_r <= '0;
            blink_r <= 1'b0;
        end
        else if (msTick)
        begin
            if (blinkCnt_r == BLINK_LAST)
            begin
                blinkCnt_r <= '0;
                blink_r <= !blink_r;
            end
            else
            begin
                blinkCnt_r <= blinkCnt_r + ssc_pkg::MS_W'(1);
            end
        end
    end

    // Actuator teach-in: the first one seen is kept until power-on reset.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            learned_r <= 1'b0;
            learnedId_r <= ssc_pkg::ID_RST;
        end
        else if (ready_r && actDetect && !learned_r)
        begin
            learned_r <= 1'b1;
            learnedId_r <= actId;
        end
    end

    assign inRange = learned_r && actDetect && (actId == learnedId_r);
    assign bothHigh = safety_in_ch1 && safety_in_ch2;
    assign bothLow = !safety_in_ch1 && !safety_in_ch2;

    // Input plausibility: mismatch on a drop, lock on a return, cleared by both low.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prevCh1_r <= 1'b0;
            prevCh2_r <= 1'b0;
            mismatch_r <= 1'b0;
            lock_r <= 1'b0;
        end
        else
        begin
            prevCh1_r <= safety_in_ch1;
            prevCh2_r <= safety_in_ch2;
            if (bothLow)
            begin
                mismatch_r <= 1'b0;
                lock_r <= 1'b0;
            end
            else
            begin
                if (prevCh1_r && prevCh2_r && (safety_in_ch1 != safety_in_ch2))
                    mismatch_r <= 1'b1;
                if (mismatch_r && bothHigh)
                    lock_r <= 1'b1;
            end
        end
    end

    assign countClamp = (faultDigitCount == 2'h0) ? ssc_pkg::CNT_ONE : faultDigitCount;

    // Fault capture: the first code is frozen until power-on reset.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fault_r <= 1'b0;
            codeCount_r <= ssc_pkg::CNT_ONE;
            code0_r <= '0;
            code1_r <= '0;
            code2_r <= '0;
            lamp_r <= ssc_pkg::LAMP_ACTUATOR;
            wiring_r <= 1'b0;
        end
        else if (faultReport && !fault_r)
        begin
            fault_r <= 1'b1;
            codeCount_r <= countClamp;
            code0_r <= faultDigit0;
            code1_r <= faultDigit1;
            code2_r <= faultDigit2;
            lamp_r <= faultLamp;
            wiring_r <= ssc_pkg::isWiringCode(countClamp, faultDigit0, faultDigit1,
                                              faultDigit2);
        end
    end

    ssc_flash_player u_player (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .msTick(msTick),
        .playEn(fault_r),
        .digitCount(codeCount_r),
        .digit0(code0_r),
        .digit1(code1_r),
        .digit2(code2_r),
        .flashOn(flashOn)
    );

    // Safety outputs follow their input only with the learned actuator present.
    // Each switch adds one input delay, so chained devices sum their delays.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            outCh1_r <= 1'b0;
            outCh2_r <= 1'b0;
            aux_r <= 1'b0;
        end
        else
        begin
            outCh1_r <= ready_r && !fault_r && inRange && !lock_r && safety_in_ch1;
            outCh2_r <= ready_r && !fault_r && inRange && !lock_r && safety_in_ch2;
            aux_r <= ready_r && !fault_r && inRange;
        end
    end

    // Lamp drive: flash code replaces normal display on the chosen lamp.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            presentLed_r <= 1'b0;
            inputLed_r <= 1'b0;
        end
        else if (fault_r)
        begin
            presentLed_r <= (lamp_r == ssc_pkg::LAMP_ACTUATOR) && flashOn;
            inputLed_r <= (lamp_r == ssc_pkg::LAMP_INPUT) && flashOn;
        end
        else
        begin
            presentLed_r <= ready_r && inRange;
            if (mismatch_r || lock_r)
                inputLed_r <= ready_r && blink_r;
            else
                inputLed_r <= ready_r && bothHigh;
        end
    end

    assign healthLedGreen = ready_r && !fault_r;
    assign healthLedRed = fault_r;
    assign actuator_present_led = presentLed_r;
    assign input_state_led = inputLed_r;
    assign safetyOutCh1 = outCh1_r;
    assign safetyOutCh2 = outCh2_r;
    assign aux_signal_out = aux_r;
    assign learnedFlag = learned_r;
    assign wiringFault = fault_r && wiring_r;
    assign internalFault = fault_r && !wiring_r;
    assign partialLock = lock_r;

    chk_learn_first_id: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(learned_r) |-> learnedId_r == $past(actId) && $past(actDetect))
        else $error("Learned identity is not the first detected actuator.");

    chk_learn_locked: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        learned_r |=> learned_r && $stable(learnedId_r))
        else $error("Learned actuator changed after teach-in.");

    chk_health_green: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        healthLedGreen |-> !healthLedRed ##1 (healthLedGreen || healthLedRed))
        else $error("Green health lamp not steady or lit with a fault.");

    chk_present_led: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (ready_r && !fault_r && inRange) |=> actuator_present_led || fault_r)
        else $error("Actuator lamp dark with learned actuator in range.");

    chk_input_steady: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (ready_r && !fault_r && bothHigh && !mismatch_r && !lock_r) |=> input_state_led || fault_r)
        else $error("Input lamp dark with both inputs high.");

    chk_fault_sticky: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        fault_r |=> fault_r && healthLedRed && $stable(code0_r) && $stable(codeCount_r))
        else $error("Fault state or code changed before reset.");

    chk_outputs_safe: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!inRange || fault_r || lock_r) |=> !safetyOutCh1 && !safetyOutCh2)
        else $error("Safety output high in the safe state.");

    chk_lock_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (mismatch_r && bothHigh && !bothLow) |=> lock_r ##1 (lock_r || $past(bothLow)))
        else $error("Plausibility lock not set or cleared without both inputs low.");

endmodule : ssc_top

`default_nettype wire

// *** rtl/ssc_pkg.sv ***
package ssc_pkg;

    // Clock rate and the millisecond tick that paces every lamp timer.
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // Lamp timing, in milliseconds.
    localparam int SHORT_ON_MS = 150;
    localparam int SHORT_OFF_MS = 150;
    localparam int PRE_PAUSE_MS = 1500;
    localparam int LONG_ON_MS = 500;
    localparam int LONG_OFF_MS = 500;
    localparam int GAP_MS = 2000;
    localparam int BLINK_HALF_MS = 250;
    localparam int POWER_ON_MS = 1000;
    localparam int MS_W = 11;

    // Flash code layout.
    localparam int PRE_FLASHES = 3;
    localparam int MAX_DIGITS = 3;
    localparam int DIGIT_W = 4;
    localparam int FLASH_W = 5;
    localparam logic [FLASH_W-1:0] ZERO_FLASHES = 5'h10;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [1:0] CNT_TWO = 2'h2;
    localparam logic [1:0] CNT_THREE = 2'h3;

    // Lamp that carries the flash code.
    localparam logic LAMP_ACTUATOR = 1'b0;
    localparam logic LAMP_INPUT = 1'b1;

    // Actuator identity width and its reset value.
    localparam int ID_W = 32;
    localparam logic [ID_W-1:0] ID_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        FL_IDLE = 3'h0,
        FL_PRE_ON = 3'h1,
        FL_PRE_OFF = 3'h3,
        FL_PAUSE = 3'h2,
        FL_DIG_ON = 3'h6,
        FL_DIG_OFF = 3'h7,
        FL_GAP = 3'h5
    } ssc_flash_state_t;

    // Number of long flashes for one digit; a zero is sent as sixteen.
    function automatic logic [FLASH_W-1:0] digitFlashes(input logic [DIGIT_W-1:0] d);
        digitFlashes = (d == 4'h0) ? ZERO_FLASHES : {1'b0, d};
    endfunction : digitFlashes

    // True for the codes that name a wiring fault.
    function automatic logic isWiringCode(input logic [1:0] n, input logic [DIGIT_W-1:0] d0,
                                          input logic [DIGIT_W-1:0] d1,
                                          input logic [DIGIT_W-1:0] d2);
        isWiringCode = (n == CNT_THREE && d0 == 4'h1 && d1 == 4'h4 && d2 == 4'h1)
            || (n == CNT_TWO && d0 == 4'h1 && (d1 == 4'hC || d1 == 4'hD))
            || (n == CNT_ONE && (d0 == 4'hE || d0 == 4'hF));
    endfunction : isWiringCode

endpackage : ssc_pkg

// *** rtl/ssc_tick_gen.sv ***
`timescale 1ns/100ps
`default_nettype none

module ssc_tick_gen #(
    parameter int CYCLES = ssc_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    output logic tick
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_r;

    // Divides the clock down to one pulse per millisecond.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_r <= '0;
        end
        else
        begin
            count_r <= (count_r == LAST) ? '0 : count_r + CW'(1);
        end
    end

    assign tick = (count_r == LAST);

endmodule : ssc_tick_gen

`default_nettype wire

// *** rtl/ssc_flash_player.sv ***
`timescale 1ns/100ps
`default_nettype none

module ssc_flash_player (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic msTick,
    input wire logic playEn,
    input wire logic [1:0] digitCount,
    input wire logic [ssc_pkg::DIGIT_W-1:0] digit0,
    input wire logic [ssc_pkg::DIGIT_W-1:0] digit1,
    input wire logic [ssc_pkg::DIGIT_W-1:0] digit2,
    output logic flashOn
);

    ssc_pkg::ssc_flash_state_t state_r;
    logic [ssc_pkg::MS_W-1:0] msCnt_r;
    logic [ssc_pkg::MS_W-1:0] phaseMs;
    logic [ssc_pkg::FLASH_W-1:0] flashIdx_r;
    logic [1:0] digIdx_r;
    logic [ssc_pkg::DIGIT_W-1:0] digSel;
    logic phaseEnd;
    logic lastFlash;
    logic [ssc_pkg::FLASH_W-1:0] preSeen_r;
    logic [ssc_pkg::FLASH_W-1:0] digSeen_r;

    // Length of the current phase in milliseconds.
    always_comb
    begin
        case (state_r)
            ssc_pkg::FL_PRE_ON: phaseMs = ssc_pkg::MS_W'(ssc_pkg::SHORT_ON_MS);
            ssc_pkg::FL_PRE_OFF: phaseMs = ssc_pkg::MS_W'(ssc_pkg::SHORT_OFF_MS);
            ssc_pkg::FL_PAUSE: phaseMs = ssc_pkg::MS_W'(ssc_pkg::PRE_PAUSE_MS);
            ssc_pkg::FL_DIG_ON: phaseMs = ssc_pkg::MS_W'(ssc_pkg::LONG_ON_MS);
            ssc_pkg::FL_DIG_OFF: phaseMs = ssc_pkg::MS_W'(ssc_pkg::LONG_OFF_MS);
            ssc_pkg::FL_GAP: phaseMs = ssc_pkg::MS_W'(ssc_pkg::GAP_MS);
            default: phaseMs = ssc_pkg::MS_W'(1);
        endcase
    end

    assign digSel = (digIdx_r == 2'h0) ? digit0 : (digIdx_r == 2'h1) ? digit1 : digit2;
    assign phaseEnd = msTick && (msCnt_r == phaseMs - ssc_pkg::MS_W'(1));
    assign lastFlash = (flashIdx_r == ssc_pkg::digitFlashes(digSel) - 5'h01);

    // Phase timer.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            msCnt_r <= '0;
        end
        else if (!playEn || state_r == ssc_pkg::FL_IDLE || phaseEnd)
        begin
            msCnt_r <= '0;
        end
        else if (msTick)
        begin
            msCnt_r <= msCnt_r + ssc_pkg::MS_W'(1);
        end
    end

    // Sequence: preamble, pause, digit groups split by gaps, then again from the preamble.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ssc_pkg::FL_IDLE;
            flashIdx_r <= '0;
            digIdx_r <= '0;
        end
        else if (!playEn)
        begin
            state_r <= ssc_pkg::FL_IDLE;
            flashIdx_r <= '0;
            digIdx_r <= '0;
        end
        else
        begin
            case (state_r)
                ssc_pkg::FL_IDLE:
                begin
                    state_r <= ssc_pkg::FL_PRE_ON;
                    flashIdx_r <= '0;
                    digIdx_r <= '0;
                end
                ssc_pkg::FL_PRE_ON:
                begin
                    if (phaseEnd)
                        state_r <= ssc_pkg::FL_PRE_OFF;
                end
                ssc_pkg::FL_PRE_OFF:
                begin
                    if (phaseEnd)
                    begin
                        if (flashIdx_r == 5'(ssc_pkg::PRE_FLASHES - 1))
                        begin
                            state_r <= ssc_pkg::FL_PAUSE;
                            flashIdx_r <= '0;
                        end
                        else
                        begin
                            state_r <= ssc_pkg::FL_PRE_ON;
                            flashIdx_r <= flashIdx_r + 5'h01;
                        end
                    end
                end
                ssc_pkg::FL_PAUSE:
                begin
                    if (phaseEnd)
                        state_r <= ssc_pkg::FL_DIG_ON;
                end
                ssc_pkg::FL_DIG_ON:
                begin
                    if (phaseEnd)
                        state_r <= ssc_pkg::FL_DIG_OFF;
                end
                ssc_pkg::FL_DIG_OFF:
                begin
                    if (phaseEnd)
                    begin
                        if (lastFlash)
                        begin
                            state_r <= ssc_pkg::FL_GAP;
                            flashIdx_r <= '0;
                        end
                        else
                        begin
                            state_r <= ssc_pkg::FL_DIG_ON;
                            flashIdx_r <= flashIdx_r + 5'h01;
                        end
                    end
                end
                ssc_pkg::FL_GAP:
                begin
                    if (phaseEnd)
                    begin
                        if (digIdx_r == digitCount - 2'h1 || digIdx_r == 2'h2)
                        begin
                            state_r <= ssc_pkg::FL_PRE_ON;
                            digIdx_r <= '0;
                        end
                        else
                        begin
                            state_r <= ssc_pkg::FL_DIG_ON;
                            digIdx_r <= digIdx_r + 2'h1;
                        end
                    end
                end
                default:
                begin
                    state_r <= ssc_pkg::FL_IDLE;
                end
            endcase
        end
    end

    assign flashOn = (state_r == ssc_pkg::FL_PRE_ON) || (state_r == ssc_pkg::FL_DIG_ON);

    // Counts flashes seen per group for the checks below.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            preSeen_r <= '0;
            digSeen_r <= '0;
        end
        else
        begin
            if (state_r == ssc_pkg::FL_PAUSE || state_r == ssc_pkg::FL_IDLE)
                preSeen_r <= '0;
            else if (state_r == ssc_pkg::FL_PRE_OFF && phaseEnd)
                preSeen_r <= preSeen_r + 5'h01;
            if (state_r == ssc_pkg::FL_GAP || state_r == ssc_pkg::FL_IDLE)
                digSeen_r <= '0;
            else if (state_r == ssc_pkg::FL_DIG_OFF && phaseEnd)
                digSeen_r <= digSeen_r + 5'h01;
        end
    end

    chk_preamble_three: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (state_r == ssc_pkg::FL_PAUSE && $past(state_r) != ssc_pkg::FL_PAUSE)
            |-> preSeen_r == 5'h03)
        else $error("Preamble did not hold three short flashes.");

    chk_digit_flashes: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (state_r == ssc_pkg::FL_GAP && $past(state_r) == ssc_pkg::FL_DIG_OFF)
            |-> digSeen_r == ssc_pkg::digitFlashes($past(digSel)))
        else $error("Digit group flash count does not match the digit.");

endmodule : ssc_flash_player

`default_nettype wire

// *** testbench/ssc_eval_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ssc_eval_model (
    input wire logic ref_clk,
    input wire logic [1:0] chMode,
    input wire logic actOn,
    input wire logic [ssc_pkg::ID_W-1:0] actSel,
    output logic actDetect,
    output logic [ssc_pkg::ID_W-1:0] actId,
    output logic safety_in_ch1,
    output logic safety_in_ch2
);
    // Channels follow the commanded mode; both low clears partial operation.
    initial
    begin
        actDetect = 1'b0;
        actId = 32'h0;
        safety_in_ch1 = 1'b0;
        safety_in_ch2 = 1'b0;
        forever
        begin
            @(negedge ref_clk);
            safety_in_ch1 <= chMode[1];
            safety_in_ch2 <= chMode[0];
            actDetect <= actOn;
            // Without an actuator the identity lines change every cycle.
            actId <= actOn ? actSel : ~actId;
        end
    end
endmodule : ssc_eval_model
`default_nettype wire

// *** testbench/test_ssc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_ssc_top;
    localparam int TC = 4;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] chMode = 2'h0;
    logic actOn = 1'b0;
    logic [31:0] actSel = 32'h0;
    logic [31:0] idA;
    logic actDetect, safety_in_ch1, safety_in_ch2;
    logic [31:0] actId;
    logic faultReport = 1'b0;
    logic faultLamp = 1'b1;
    logic [1:0] fdc = 2'h0;
    logic [3:0] fd0 = 4'h0;
    logic [3:0] fd1 = 4'h0;
    logic [3:0] fd2 = 4'h0;
    logic hG, hR, actLed, inLed, so1, so2, aux, learned, wirF, intF, lock;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int edges;
    always #5 ref_clk = ~ref_clk;
    ssc_eval_model u_ssc_eval_model (.ref_clk(ref_clk), .chMode(chMode), .actOn(actOn),
        .actSel(actSel), .actDetect(actDetect), .actId(actId),
        .safety_in_ch1(safety_in_ch1), .safety_in_ch2(safety_in_ch2));
    ssc_top #(.TICK_CYCLES(TC)) u_ssc_top (.ref_clk(ref_clk), .rst_b(rst_b),
        .actDetect(actDetect), .actId(actId), .safety_in_ch1(safety_in_ch1),
        .safety_in_ch2(safety_in_ch2), .faultReport(faultReport), .faultDigitCount(fdc),
        .faultDigit0(fd0), .faultDigit1(fd1), .faultDigit2(fd2), .faultLamp(faultLamp),
        .healthLedGreen(hG), .healthLedRed(hR), .actuator_present_led(actLed),
        .input_state_led(inLed), .safetyOutCh1(so1), .safetyOutCh2(so2),
        .aux_signal_out(aux), .learnedFlag(learned), .wiringFault(wirF),
        .internalFault(intF), .partialLock(lock));
    task automatic test_done();
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic waitCy(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : waitCy
    task automatic countRise(input logic onAct, input int n);
        logic prev;
        edges = 0;
        prev = onAct ? actLed : inLed;
        repeat (n)
        begin
            @(negedge ref_clk);
            if ((onAct ? actLed : inLed) === 1'b1 && prev === 1'b0)
                edges++;
            prev = onAct ? actLed : inLed;
        end
    endtask : countRise
    task automatic doReset();
        rst_b = 1'b0;
        waitCy(16);
        rst_b = 1'b1;
        waitCy(2);
        chk({hG, hR, so1, so2, aux, learned}, 6'h0);
        waitCy(ssc_pkg::POWER_ON_MS * TC + 8);
    endtask : doReset
    task automatic pulseFault();
        faultReport = 1'b1;
        waitCy(1);
        faultReport = 1'b0;
    endtask : pulseFault
    function automatic int fl(input logic [3:0] d);
        return (d == 4'h0) ? 16 : int'(d);
    endfunction : fl
    initial
    begin
        idA = $urandom(96);
        doReset();
        chk(hG, 1'h1);
        idA = $urandom();
        actSel = idA;
        actOn = 1'b1;
        waitCy(4);
        chk({learned, actLed, aux}, 3'h7);
        actOn = 1'b0;
        waitCy(4);
        chk(actLed, 1'h0);
        actSel = idA ^ ($urandom() | 32'h1);
        actOn = 1'b1;
        waitCy(4);
        chk(actLed, 1'h0);
        actSel = idA;
        chMode = 2'h3;
        waitCy(4);
        chk({so1, so2, inLed, lock}, 4'hE);
        chMode = 2'h2;
        countRise(1'b0, 600 * TC);
        chk(edges > 0, 1'h1);
        chMode = 2'h3;
        waitCy(4);
        chk({lock, so1, so2}, 3'h4);
        chMode = 2'h0;
        waitCy(4);
        chMode = 2'h3;
        waitCy(4);
        chk({lock, so1, so2}, 3'h3);
        actOn = 1'b0;
        waitCy(4);
        chk({so1, so2, aux}, 3'h0);
        chMode = 2'h0;
        fdc = 2'h2;
        fd0 = 4'h1;
        fd1 = 4'h2;
        pulseFault();
        countRise(1'b0, (900 + 1500 + (fl(fd0) + fl(fd1)) * 1000 + 4000 + 800) * TC);
        chk(edges, 6 + fl(fd0) + fl(fd1));
        chk({hR, hG, intF, wirF}, 4'hA);
        fdc = 2'h1;
        fd0 = 4'hE | 4'($urandom() & 1);
        pulseFault();
        waitCy(4);
        chk({hR, intF, wirF}, 3'h6);
        doReset();
        chk(hR, 1'h0);
        faultLamp = 1'b0;
        pulseFault();
        countRise(1'b1, 1000 * TC);
        chk(edges, 3);
        chk({hR, wirF, intF}, 3'h6);
        test_done();
    end
endmodule : test_ssc_top
`default_nettype wire
